// ==== verilog/ecp_pkg.sv ====
// constants for the command-mode escape detector and parameter set
// assumes one 250 MHz clock and a host that sends parsed commands
package ecp_pkg;

  // parameter indices on the command port
  localparam logic [3:0] IDX_OPTIONS = 4'h0;
  localparam logic [3:0] IDX_SUPPLY = 4'h1;
  localparam logic [3:0] IDX_THRESH = 4'h2;
  localparam logic [3:0] IDX_TEMP = 4'h3;
  localparam logic [3:0] IDX_FW_REV = 4'h4;
  localparam logic [3:0] IDX_HW_REV = 4'h5;
  localparam logic [3:0] IDX_JOIN = 4'h6;
  localparam logic [3:0] IDX_TIMEOUT = 4'h7;
  localparam logic [3:0] IDX_GUARD = 4'h8;
  localparam logic [3:0] IDX_ESC = 4'h9;
  localparam logic [3:0] IDX_SLEEP_MODE = 4'hA;
  localparam logic [3:0] IDX_SLEEP_PER = 4'hB;

  // option bit positions, and the supply bit of the sample mask
  localparam int OPT_BEST_JOIN = 2;
  localparam int OPT_NO_NULL_KEY = 3;
  localparam int OPT_NO_EXT_TMO = 4;
  localparam int OPT_NO_IO_ACK = 5;
  localparam int OPT_HIGH_RAM = 6;
  localparam int OPT_SEARCH_LEAVE = 7;
  localparam int MASK_SUPPLY_BIT = 7;

  // reset values
  localparam logic [7:0] RST_OPTIONS = 8'h00;
  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [15:0] RST_TIMEOUT = 16'h0064;
  localparam logic [15:0] RST_GUARD = 16'h03E8;
  localparam logic [7:0] RST_ESC = 8'h2B;
  localparam logic [7:0] RST_SLEEP_MODE = 8'h00;
  localparam logic [15:0] RST_SLEEP_PER = 16'h0001;
  localparam logic [7:0] JOIN_INIT = 8'hFF;

  // legal ranges
  localparam logic [15:0] TIMEOUT_MIN = 16'h0002;
  localparam logic [15:0] TIMEOUT_MAX = 16'h1770;
  localparam logic [15:0] GUARD_MIN = 16'h0001;
  localparam logic [15:0] GUARD_MAX = 16'h0CE4;
  localparam logic [15:0] SLEEP_PER_MIN = 16'h0001;

  // sleep mode codes
  localparam logic [7:0] SM_ROUTER = 8'h01;
  localparam logic [7:0] SM_PIN = 8'h02;
  localparam logic [7:0] SM_CYCLIC = 8'h04;
  localparam logic [7:0] SM_CYCLIC_PIN = 8'h05;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CLKS_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TIMEOUT_UNIT_MS = 7'd100;
  localparam logic [1:0] ESC_COUNT = 2'd3;

  typedef enum logic [1:0] {
    ECP_OP_READ,
    ECP_OP_WRITE,
    ECP_OP_APPLY,
    ECP_OP_EXIT
  } ecp_op_t;

  typedef enum logic [1:0] {
    ECP_ESC_IDLE,
    ECP_ESC_CHARS,
    ECP_ESC_POST
  } ecp_esc_t;

endpackage

// ==== verilog/ecp_escape_config.sv ====
// escape detection, command mode timing and the parameter set
// assumes a receiver delivering serial bytes as one-cycle strobes and a
// command parser delivering decoded commands, both on sys_clk
`timescale 1ns/100ps
module ecp_escape_config #(
  parameter int CLKS_PER_MS = ecp_pkg::CLKS_PER_MS,
  parameter logic [15:0] FW_REVISION = 16'h1234, // arbitrary value
  parameter logic [7:0] HW_DEVICE_TYPE = 8'h5A, // arbitrary value
  parameter logic [7:0] HW_REVISION = 8'h01 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic coordinator_role,
  input wire logic supply_valid,
  input wire logic [15:0] supply_mv,
  input wire logic [15:0] temp_c,
  input wire logic join_event,
  input wire logic [7:0] join_code,
  input wire logic [7:0] analog_mask,
  input wire logic sleep_period_end,
  input wire logic rf_data_waiting,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_data,
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic command_mode,
  output logic best_join,
  output logic disable_null_key,
  output logic disable_ext_timeout,
  output logic disable_io_ack,
  output logic high_ram_concentrator,
  output logic search_before_leave,
  output logic append_supply,
  output logic [7:0] sample_analog_mask,
  output logic end_device,
  output logic pin_sleep_en,
  output logic cyclic_sleep_en,
  output logic pin_wake_en,
  output logic rejoin_req,
  output logic awake_pulse
);

  // queued (written) and active (applied) copies of writable settings
  logic [7:0] q_options, a_options;
  logic [15:0] q_thresh, a_thresh;
  logic [15:0] q_timeout, a_timeout;
  logic [15:0] q_guard, a_guard;
  logic [7:0] q_esc, a_esc;
  logic [7:0] q_sleep_mode, a_sleep_mode;
  logic [15:0] q_sleep_per, a_sleep_per;

  logic [15:0] supply_level, temp_level;
  logic [7:0] join_status;

  logic [31:0] div_cnt;
  logic ms_tick;
  logic [15:0] silence_ms, idle_units, period_cnt;
  logic [1:0] esc_seen;
  ecp_pkg::ecp_esc_t esc_state;
  logic [6:0] unit_ms;

  logic is_read, is_write, is_apply, is_exit, in_cmd, wr_ok, apply_now;
  logic enter_cmd, guard_met, sm_legal, rd_ok, q_end_dev;
  logic [15:0] rd_data;

  assign in_cmd = cmd_valid && command_mode;
  assign is_read = in_cmd && (cmd_op == ecp_pkg::ECP_OP_READ);
  assign is_write = in_cmd && (cmd_op == ecp_pkg::ECP_OP_WRITE);
  assign is_apply = in_cmd && (cmd_op == ecp_pkg::ECP_OP_APPLY);
  assign is_exit = in_cmd && (cmd_op == ecp_pkg::ECP_OP_EXIT);
  assign apply_now = is_apply || is_exit;
  assign guard_met = silence_ms >= a_guard;

  // only the documented sleep codes, and only code 0 while coordinator
  always_comb begin
    unique case (cmd_wdata[7:0])
      ecp_pkg::RST_SLEEP_MODE: sm_legal = 1'b1;
      ecp_pkg::SM_ROUTER,
      ecp_pkg::SM_PIN,
      ecp_pkg::SM_CYCLIC,
      ecp_pkg::SM_CYCLIC_PIN: sm_legal = !coordinator_role;
      default: sm_legal = 1'b0;
    endcase
  end

  // write acceptance with range checks; read-only words refuse writes
  always_comb begin
    wr_ok = 1'b0;
    unique case (cmd_index)
      ecp_pkg::IDX_OPTIONS: wr_ok = (cmd_wdata[15:8] == 8'h00);
      ecp_pkg::IDX_THRESH: wr_ok = 1'b1;
      ecp_pkg::IDX_TIMEOUT:
        wr_ok = (cmd_wdata >= ecp_pkg::TIMEOUT_MIN) &&
                (cmd_wdata <= ecp_pkg::TIMEOUT_MAX);
      ecp_pkg::IDX_GUARD:
        wr_ok = (cmd_wdata >= ecp_pkg::GUARD_MIN) &&
                (cmd_wdata <= ecp_pkg::GUARD_MAX);
      ecp_pkg::IDX_ESC: wr_ok = (cmd_wdata[15:8] == 8'h00);
      ecp_pkg::IDX_SLEEP_MODE:
        wr_ok = (cmd_wdata[15:8] == 8'h00) && sm_legal;
      ecp_pkg::IDX_SLEEP_PER:
        wr_ok = cmd_wdata >= ecp_pkg::SLEEP_PER_MIN;
      default: wr_ok = 1'b0;
    endcase
  end

  // reads show queued values for settings and live state otherwise
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 16'h0000;
    unique case (cmd_index)
      ecp_pkg::IDX_OPTIONS: rd_data = {8'h00, q_options};
      ecp_pkg::IDX_SUPPLY: rd_data = supply_level;
      ecp_pkg::IDX_THRESH: rd_data = q_thresh;
      ecp_pkg::IDX_TEMP: rd_data = temp_level;
      ecp_pkg::IDX_FW_REV: rd_data = FW_REVISION;
      ecp_pkg::IDX_HW_REV:
        rd_data = {HW_DEVICE_TYPE, HW_REVISION};
      ecp_pkg::IDX_JOIN: rd_data = {8'h00, join_status};
      ecp_pkg::IDX_TIMEOUT: rd_data = q_timeout;
      ecp_pkg::IDX_GUARD: rd_data = q_guard;
      ecp_pkg::IDX_ESC: rd_data = {8'h00, q_esc};
      ecp_pkg::IDX_SLEEP_MODE: rd_data = {8'h00, q_sleep_mode};
      ecp_pkg::IDX_SLEEP_PER: rd_data = q_sleep_per;
      default: rd_ok = 1'b0;
    endcase
  end

  // command answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_err <= cmd_valid && !(is_apply || is_exit ||
                 (is_read && rd_ok) || (is_write && wr_ok));
      rsp_data <= (is_read && rd_ok) ? rd_data : 16'h0000;
    end
  end

  // queued settings
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_options <= ecp_pkg::RST_OPTIONS;
      q_thresh <= ecp_pkg::RST_THRESH;
      q_timeout <= ecp_pkg::RST_TIMEOUT;
      q_guard <= ecp_pkg::RST_GUARD;
      q_esc <= ecp_pkg::RST_ESC;
      q_sleep_mode <= ecp_pkg::RST_SLEEP_MODE;
      q_sleep_per <= ecp_pkg::RST_SLEEP_PER;
    end else if (is_write && wr_ok) begin
      unique case (cmd_index)
        ecp_pkg::IDX_OPTIONS: q_options <= cmd_wdata[7:0];
        ecp_pkg::IDX_THRESH: q_thresh <= cmd_wdata;
        ecp_pkg::IDX_TIMEOUT: q_timeout <= cmd_wdata;
        ecp_pkg::IDX_GUARD: q_guard <= cmd_wdata;
        ecp_pkg::IDX_ESC: q_esc <= cmd_wdata[7:0];
        ecp_pkg::IDX_SLEEP_MODE: q_sleep_mode <= cmd_wdata[7:0];
        ecp_pkg::IDX_SLEEP_PER: q_sleep_per <= cmd_wdata;
        default: q_options <= q_options;
      endcase
    end
  end

  assign q_end_dev = q_sleep_mode > ecp_pkg::SM_ROUTER;

  // active settings take the queued ones on apply or exit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      a_options <= ecp_pkg::RST_OPTIONS;
      a_thresh <= ecp_pkg::RST_THRESH;
      a_timeout <= ecp_pkg::RST_TIMEOUT;
      a_guard <= ecp_pkg::RST_GUARD;
      a_esc <= ecp_pkg::RST_ESC;
      a_sleep_mode <= ecp_pkg::RST_SLEEP_MODE;
      a_sleep_per <= ecp_pkg::RST_SLEEP_PER;
      rejoin_req <= 1'b0;
    end else begin
      rejoin_req <= 1'b0;
      if (apply_now) begin
        a_options <= q_options;
        a_thresh <= q_thresh;
        a_timeout <= q_timeout;
        a_guard <= q_guard;
        a_esc <= q_esc;
        a_sleep_mode <= q_sleep_mode;
        a_sleep_per <= q_sleep_per;
        rejoin_req <= q_end_dev !=
                      (a_sleep_mode > ecp_pkg::SM_ROUTER);
      end
    end
  end

  // decoded controls for the stack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      best_join <= 1'b0;
      disable_null_key <= 1'b0;
      disable_ext_timeout <= 1'b0;
      disable_io_ack <= 1'b0;
      high_ram_concentrator <= 1'b0;
      search_before_leave <= 1'b0;
    end else begin
      best_join <= a_options[ecp_pkg::OPT_BEST_JOIN];
      // null key control has meaning on a coordinator only
      disable_null_key <= a_options[ecp_pkg::OPT_NO_NULL_KEY] &&
                          coordinator_role;
      disable_ext_timeout <= a_options[ecp_pkg::OPT_NO_EXT_TMO];
      disable_io_ack <= a_options[ecp_pkg::OPT_NO_IO_ACK];
      high_ram_concentrator <= a_options[ecp_pkg::OPT_HIGH_RAM];
      search_before_leave <= a_options[ecp_pkg::OPT_SEARCH_LEAVE];
    end
  end

  // sleep mode decode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      end_device <= 1'b0;
      pin_sleep_en <= 1'b0;
      cyclic_sleep_en <= 1'b0;
      pin_wake_en <= 1'b0;
    end else begin
      end_device <= a_sleep_mode > ecp_pkg::SM_ROUTER;
      pin_sleep_en <= a_sleep_mode == ecp_pkg::SM_PIN;
      cyclic_sleep_en <= (a_sleep_mode == ecp_pkg::SM_CYCLIC) ||
                         (a_sleep_mode == ecp_pkg::SM_CYCLIC_PIN);
      pin_wake_en <= a_sleep_mode == ecp_pkg::SM_CYCLIC_PIN;
    end
  end

  // measured values and association outcome
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      supply_level <= 16'h0000;
      temp_level <= 16'h0000;
      join_status <= ecp_pkg::JOIN_INIT;
    end else begin
      if (supply_valid) begin
        supply_level <= supply_mv;
      end
      temp_level <= temp_c;
      // codes pass through as the stack reports them
      if (join_event) begin
        join_status <= join_code;
      end
    end
  end

  // low supply flag rides along with every sample set
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      append_supply <= 1'b0;
      sample_analog_mask <= 8'h00;
    end else begin
      append_supply <= (a_thresh != 16'h0000) &&
                       (supply_level <= a_thresh);
      sample_analog_mask <= analog_mask;
      if ((a_thresh != 16'h0000) && (supply_level <= a_thresh)) begin
        sample_analog_mask[ecp_pkg::MASK_SUPPLY_BIT] <= 1'b1;
      end
    end
  end

  // millisecond enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (div_cnt == 32'(CLKS_PER_MS - 1)) begin
      div_cnt <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end

  // line silence in ms, saturating; any byte restarts it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      silence_ms <= 16'h0000;
    end else if (rx_valid) begin
      silence_ms <= 16'h0000;
    end else if (ms_tick && silence_ms != 16'hFFFF) begin
      silence_ms <= silence_ms + 16'h0001;
    end
  end

  assign enter_cmd = (esc_state == ecp_pkg::ECP_ESC_POST) && !rx_valid &&
                     guard_met;

  // escape sequence: silence, escape characters, silence
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      esc_state <= ecp_pkg::ECP_ESC_IDLE;
      esc_seen <= 2'd0;
    end else if (command_mode) begin
      esc_state <= ecp_pkg::ECP_ESC_IDLE;
      esc_seen <= 2'd0;
    end else begin
      unique case (esc_state)
        ecp_pkg::ECP_ESC_IDLE: begin
          if (rx_valid && rx_byte == a_esc && guard_met) begin
            esc_state <= (ecp_pkg::ESC_COUNT == 2'd1) ?
                         ecp_pkg::ECP_ESC_POST : ecp_pkg::ECP_ESC_CHARS;
            esc_seen <= 2'd1;
          end
        end
        ecp_pkg::ECP_ESC_CHARS: begin
          if (rx_valid) begin
            if (rx_byte != a_esc) begin
              esc_state <= ecp_pkg::ECP_ESC_IDLE;
            end else if (esc_seen + 2'd1 == ecp_pkg::ESC_COUNT) begin
              esc_state <= ecp_pkg::ECP_ESC_POST;
            end
            esc_seen <= esc_seen + 2'd1;
          end
        end
        ecp_pkg::ECP_ESC_POST: begin
          // a byte inside the trailing guard abandons the attempt
          if (rx_valid || guard_met) begin
            esc_state <= ecp_pkg::ECP_ESC_IDLE;
          end
        end
      endcase
    end
  end

  // bytes outside command mode are ordinary data, escapes included
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_valid <= 1'b0;
      data_byte <= 8'h00;
    end else begin
      data_valid <= rx_valid && !command_mode;
      data_byte <= rx_byte;
    end
  end

  // command mode with idle timeout in 100 ms units
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      command_mode <= 1'b0;
      unit_ms <= 7'd0;
      idle_units <= 16'h0000;
    end else if (!command_mode) begin
      command_mode <= enter_cmd;
      unit_ms <= 7'd0;
      idle_units <= 16'h0000;
    end else if (is_exit) begin
      command_mode <= 1'b0;
    end else if (cmd_valid) begin
      // only an accepted command restarts the timer
      if (is_apply || (is_read && rd_ok) || (is_write && wr_ok)) begin
        unit_ms <= 7'd0;
        idle_units <= 16'h0000;
      end
    end else if (idle_units >= a_timeout) begin
      command_mode <= 1'b0;
    end else if (ms_tick) begin
      if (unit_ms == ecp_pkg::TIMEOUT_UNIT_MS - 7'd1) begin
        unit_ms <= 7'd0;
        idle_units <= idle_units + 16'h0001;
      end else begin
        unit_ms <= unit_ms + 7'd1;
      end
    end
  end

  // awake indication once per configured number of sleep periods
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      period_cnt <= 16'h0000;
      awake_pulse <= 1'b0;
    end else begin
      awake_pulse <= 1'b0;
      if (sleep_period_end) begin
        // waiting radio data wakes the host every period
        if (rf_data_waiting ||
            period_cnt + 16'h0001 >= a_sleep_per) begin
          period_cnt <= 16'h0000;
          awake_pulse <= 1'b1;
        end else begin
          period_cnt <= period_cnt + 16'h0001;
        end
      end
    end
  end

endmodule

// ==== dv/ecp_escape_config_props.sv ====
// port assertions for the escape detector and parameter set
// assumes binding to ecp_escape_config, one clock, active-low reset
`timescale 1ns/100ps
module ecp_escape_config_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] cmd_index,
  input wire logic coordinator_role,
  input wire logic sleep_period_end,
  input wire logic rf_data_waiting,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic command_mode,
  input wire logic disable_null_key,
  input wire logic end_device,
  input wire logic pin_sleep_en,
  input wire logic cyclic_sleep_en,
  input wire logic pin_wake_en,
  input wire logic rejoin_req,
  input wire logic awake_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // read-only slots
  AST_RO_WRITE: assert property (
    cmd_valid && cmd_op == ecp_pkg::ECP_OP_WRITE &&
    cmd_index inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6} |=> rsp_valid && rsp_err)
    else $error("write to read-only slot accepted");
  AST_EXIT_NOW: assert property (
    cmd_valid && cmd_op == ecp_pkg::ECP_OP_EXIT |=> !command_mode)
    else $error("command mode kept after exit");
  AST_DATA_FWD: assert property (
    rx_valid && !command_mode |=> data_valid && data_byte == $past(rx_byte))
    else $error("idle byte not forwarded");
  AST_DATA_QUIET: assert property (
    !rx_valid |=> !data_valid)
    else $error("data forwarded without a received byte");
  AST_WAKE_DEC: assert property (
    pin_wake_en |-> cyclic_sleep_en && end_device && !pin_sleep_en)
    else $error("pin wake without cyclic end device");
  AST_CYC_DEC: assert property (
    cyclic_sleep_en || pin_sleep_en |-> end_device &&
    !(cyclic_sleep_en && pin_sleep_en))
    else $error("sleep enables inconsistent");
  AST_NULL_KEY: assert property (
    disable_null_key |-> $past(coordinator_role))
    else $error("null key disable outside coordinator");
  AST_AWAKE_CAUSE: assert property (
    awake_pulse |-> $past(sleep_period_end))
    else $error("awake pulse without a sleep period");
  AST_AWAKE_RF: assert property (
    sleep_period_end && rf_data_waiting |=> awake_pulse)
    else $error("no awake pulse with data waiting");
  AST_REJOIN: assert property (
    rejoin_req |-> $past(cmd_valid) &&
    $past(cmd_op) inside {ecp_pkg::ECP_OP_APPLY, ecp_pkg::ECP_OP_EXIT})
    else $error("rejoin without apply or exit");
endmodule

// ==== dv/ecp_host_model.sv ====
// host processor model: serial bytes and decoded commands
// assumes sys_clk from the bench and CPM cycles per millisecond
`timescale 1ns/100ps
module ecp_host_model #(
  parameter int CPM = 4
) (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic cmd_valid,
  output logic [1:0] cmd_op,
  output logic [3:0] cmd_index,
  output logic [15:0] cmd_wdata
);
  logic [7:0] sent_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_index = 4'h0;
    cmd_wdata = 16'h0000;
  end
  task automatic send_byte(logic [7:0] b);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b1;
    rx_byte = b;
    sent_q.push_back(b);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    rx_byte = ~b; // stale lane must differ
  endtask
  task automatic silence(int ms);
    repeat (ms * CPM) @(posedge sys_clk);
    #1;
  endtask
  // two spare ms cover tick slack
  task automatic escape(logic [7:0] c, int gt, bit intrude);
    silence(gt + 2);
    repeat (ecp_pkg::ESC_COUNT) send_byte(c);
    if (intrude) send_byte(8'h00);
    silence(gt + 2);
  endtask
  task automatic command(logic [1:0] op, logic [3:0] i, logic [15:0] w);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = i;
    cmd_wdata = w;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_index = ~i;
    cmd_wdata = ~w;
  endtask
endmodule

// ==== dv/ecp_escape_config_bench.sv ====
// self-checking bench for the escape detector and parameter set
// assumes a 4-cycle millisecond so guard and timeout spans stay short
`timescale 1ns/100ps
module ecp_escape_config_bench;
  localparam int CPM = 4;
  localparam logic [15:0] FW = 16'h0A5C; // arbitrary value
  localparam logic [7:0] HWT = 8'h3C; // arbitrary value
  localparam logic [7:0] HWR = 8'h07; // arbitrary value
  logic sys_clk, rstn, coordinator_role, supply_valid, join_event;
  logic sleep_period_end, rf_data_waiting, rx_valid, cmd_valid;
  logic [15:0] supply_mv, temp_c, cmd_wdata, rsp_data;
  logic [7:0] join_code, analog_mask, rx_byte, data_byte, opts, mask, d;
  logic [1:0] cmd_op;
  logic [3:0] cmd_index, sl;
  logic rsp_valid, rsp_err, data_valid, command_mode, append_supply;
  logic best_join, disable_null_key, disable_ext_timeout, disable_io_ack;
  logic high_ram_concentrator, search_before_leave, end_device;
  logic pin_sleep_en, cyclic_sleep_en, pin_wake_en, rejoin_req, awake_pulse;
  logic [7:0] sample_analog_mask;
  logic [5:0] opt_out;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  int error_cnt = 0;
  int compares = 0;
  int rejoin_n = 0;
  int awake_n = 0;
  logic [7:0] codes[10] = '{8'h21, 8'h24, 8'h27, 8'h2A, 8'h2B, 8'h2C,
    8'hAB, 8'hAD, 8'hAF, 8'h00};
  // mode code, then end device, pin sleep, cyclic, pin wake
  logic [11:0] modes[4] = '{12'h010, 12'h02C, 12'h04A, 12'h05B};
  ecp_escape_config #(.CLKS_PER_MS(CPM), .FW_REVISION(FW),
    .HW_DEVICE_TYPE(HWT), .HW_REVISION(HWR)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
    .cmd_wdata(cmd_wdata), .coordinator_role(coordinator_role),
    .supply_valid(supply_valid), .supply_mv(supply_mv), .temp_c(temp_c),
    .join_event(join_event), .join_code(join_code),
    .analog_mask(analog_mask), .sleep_period_end(sleep_period_end),
    .rf_data_waiting(rf_data_waiting), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .data_valid(data_valid),
    .data_byte(data_byte), .command_mode(command_mode),
    .best_join(best_join), .disable_null_key(disable_null_key),
    .disable_ext_timeout(disable_ext_timeout),
    .disable_io_ack(disable_io_ack),
    .high_ram_concentrator(high_ram_concentrator),
    .search_before_leave(search_before_leave),
    .append_supply(append_supply), .sample_analog_mask(sample_analog_mask),
    .end_device(end_device), .pin_sleep_en(pin_sleep_en),
    .cyclic_sleep_en(cyclic_sleep_en), .pin_wake_en(pin_wake_en),
    .rejoin_req(rejoin_req), .awake_pulse(awake_pulse));
  ecp_host_model #(.CPM(CPM)) host_u (.sys_clk(sys_clk),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata));
  task automatic chk(string n, logic [16:0] x, logic [16:0] g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic cm_chk(logic x);
    chk("command_mode", 17'(x), 17'(command_mode));
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(logic [1:0] op, logic [3:0] i, logic [15:0] w,
    logic er, logic [15:0] x);
    exp_q.push_back({er, x});
    host_u.command(op, i, w);
  endtask
  task automatic wr(logic [3:0] i, logic [15:0] w, logic er);
    cmd(ecp_pkg::ECP_OP_WRITE, i, w, er, 16'h0000);
  endtask
  task automatic rd(logic [3:0] i, logic [15:0] x);
    cmd(ecp_pkg::ECP_OP_READ, i, 16'h0000, 1'b0, x);
  endtask
  task automatic apply_wait();
    cmd(ecp_pkg::ECP_OP_APPLY, 4'h0, 16'h0000, 1'b0, 16'h0000);
    tick(2);
  endtask
  task automatic supply(logic [15:0] mv);
    supply_valid = 1'b1;
    supply_mv = mv;
    tick(1);
    supply_valid = 1'b0;
    tick(3);
  endtask
  task automatic period();
    sleep_period_end = 1'b1;
    tick(1);
    sleep_period_end = 1'b0;
    tick(2);
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : {17{1'bx}};
      chk("response", e, {rsp_err, rsp_data});
    end
    if (data_valid === 1'b1) begin
      d = host_u.sent_q.size() ? host_u.sent_q.pop_front() : {8{1'bx}};
      chk("data_byte", 17'(d), 17'(data_byte));
    end
    if (rejoin_req === 1'b1) rejoin_n++;
    if (awake_pulse === 1'b1) awake_n++;
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // whole run is near 10000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    rstn = 1'b0;
    coordinator_role = 1'b0;
    supply_valid = 1'b0;
    supply_mv = 16'h0000;
    temp_c = 16'hFFFF;
    join_event = 1'b0;
    join_code = 8'h00;
    analog_mask = 8'h00;
    sleep_period_end = 1'b0;
    rf_data_waiting = 1'b0;
    void'($urandom(32'h7487));
    tick(3);
    rstn = 1'b1;
    tick(1);
    cmd(ecp_pkg::ECP_OP_READ, ecp_pkg::IDX_JOIN, 16'h0000, 1'b1, 16'h0000);
    repeat (4) host_u.send_byte(8'($urandom_range(8'h2A)));
    host_u.escape(8'h2B, 1000, 1'b0);
    cm_chk(1'b1);
    rd(ecp_pkg::IDX_JOIN, 16'h00FF);
    rd(ecp_pkg::IDX_GUARD, 16'h03E8);
    rd(ecp_pkg::IDX_ESC, 16'h002B);
    rd(ecp_pkg::IDX_OPTIONS, 16'h0000);
    rd(ecp_pkg::IDX_THRESH, 16'h0000);
    rd(ecp_pkg::IDX_SLEEP_PER, 16'h0001);
    rd(ecp_pkg::IDX_FW_REV, FW);
    rd(ecp_pkg::IDX_HW_REV, {HWT, HWR});
    rd(ecp_pkg::IDX_TEMP, 16'hFFFF);
    temp_c = 16'h0001;
    rd(ecp_pkg::IDX_TEMP, 16'h0001);
    foreach (codes[k]) begin
      join_event = 1'b1;
      join_code = codes[k];
      tick(1);
      join_event = 1'b0;
      rd(ecp_pkg::IDX_JOIN, 16'(codes[k]));
    end
    wr(ecp_pkg::IDX_GUARD, 16'h0000, 1'b1);
    wr(ecp_pkg::IDX_GUARD, 16'h0CE5, 1'b1);
    wr(ecp_pkg::IDX_GUARD, 16'h0CE4, 1'b0);
    wr(ecp_pkg::IDX_TIMEOUT, 16'h0001, 1'b1);
    wr(ecp_pkg::IDX_TIMEOUT, 16'h1771, 1'b1);
    wr(ecp_pkg::IDX_TIMEOUT, 16'h1770, 1'b0);
    wr(ecp_pkg::IDX_SLEEP_PER, 16'h0000, 1'b1);
    wr(ecp_pkg::IDX_SLEEP_MODE, 16'h0003, 1'b1);
    wr(ecp_pkg::IDX_SUPPLY, 16'h0001, 1'b1);
    wr(ecp_pkg::IDX_FW_REV, 16'h0001, 1'b1);
    coordinator_role = 1'b1;
    opts = 8'($urandom) | 8'h08;
    repeat (2) begin
      wr(ecp_pkg::IDX_OPTIONS, 16'(opts), 1'b0);
      apply_wait();
      opt_out = {search_before_leave, high_ram_concentrator, disable_io_ack,
        disable_ext_timeout, disable_null_key, best_join};
      chk("options", 17'(opts[7:2]), 17'(opt_out));
      rd(ecp_pkg::IDX_OPTIONS, 16'(opts));
      opts = ~opts;
    end
    wr(ecp_pkg::IDX_SLEEP_MODE, 16'h0004, 1'b1);
    coordinator_role = 1'b0;
    foreach (modes[k]) begin
      wr(ecp_pkg::IDX_SLEEP_MODE, 16'(modes[k][11:4]), 1'b0);
      apply_wait();
      sl = {end_device, pin_sleep_en, cyclic_sleep_en, pin_wake_en};
      chk("sleep_decode", 17'(modes[k][3:0]), 17'(sl));
    end
    supply(16'h0064);
    chk("append_supply", 17'h00000, 17'(append_supply));
    wr(ecp_pkg::IDX_THRESH, 16'h0CE4, 1'b0);
    apply_wait();
    mask = 8'($urandom) & 8'h7F;
    analog_mask = mask;
    supply(16'h0CE4);
    chk("append_supply", 17'h00001, 17'(append_supply));
    chk("mask", 17'(mask | 8'h80), 17'(sample_analog_mask));
    supply(16'h0CE5);
    chk("append_supply", 17'h00000, 17'(append_supply));
    rd(ecp_pkg::IDX_SUPPLY, 16'h0CE5);
    wr(ecp_pkg::IDX_SLEEP_PER, 16'h0003, 1'b0);
    apply_wait();
    repeat (6) period();
    chk("awake_count", 17'h00002, 17'(awake_n));
    rf_data_waiting = 1'b1;
    repeat (2) period();
    chk("awake_count", 17'h00004, 17'(awake_n));
    rf_data_waiting = 1'b0;
    wr(ecp_pkg::IDX_ESC, 16'h0041, 1'b0);
    wr(ecp_pkg::IDX_GUARD, 16'h0002, 1'b0);
    wr(ecp_pkg::IDX_SLEEP_MODE, 16'h0001, 1'b0);
    cmd(ecp_pkg::ECP_OP_EXIT, 4'h0, 16'h0000, 1'b0, 16'h0000);
    cm_chk(1'b0);
    tick(2);
    chk("rejoin_count", 17'h00002, 17'(rejoin_n));
    host_u.silence(4);
    host_u.send_byte(8'h41);
    host_u.send_byte(8'h41);
    host_u.send_byte(8'h42);
    host_u.silence(4);
    cm_chk(1'b0);
    host_u.escape(8'h41, 2, 1'b1);
    cm_chk(1'b0);
    host_u.escape(8'h41, 2, 1'b0);
    cm_chk(1'b1);
    wr(ecp_pkg::IDX_TIMEOUT, 16'h0002, 1'b0);
    apply_wait();
    tick(188 * CPM);
    cm_chk(1'b1);
    tick(20 * CPM);
    cm_chk(1'b0);
    tick(2);
    chk("pending", 17'h00000, 17'(exp_q.size() + host_u.sent_q.size()));
    end_of_test;
  end
endmodule
bind ecp_escape_config ecp_escape_config_props props_u (.*);
